/* hw/core_regs_pkg.sv */
package core_regs_pkg;

	// register widths
	localparam int DATA_W = 8;
	localparam int ADDR_W = 16;

	// condition flag bit positions
	localparam int FLAG_CARRY = 0;
	localparam int FLAG_ZERO = 1;
	localparam int FLAG_SIGN = 2;
	localparam int FLAG_MASK = 3;
	localparam int FLAG_NIBBLE = 4;

	// reset values
	localparam logic [7:0] FLAGS_RESET = 8'hE8;
	localparam logic [7:0] FLAGS_FIXED_ONES = 8'hE0;
	localparam logic [15:0] STACK_RESET = 16'h01FF;
	localparam logic [7:0] STACK_PAGE = 8'h01;
	localparam logic [7:0] STACK_LOW_TOP = 8'hFF;
	localparam logic [15:0] RESET_VECTOR_LO = 16'hFFFE;
	localparam logic [15:0] RESET_VECTOR_HI = 16'hFFFF;
	localparam logic [15:0] TRAP_VECTOR_LO = 16'hFFFC;

	// stack usage
	localparam logic [2:0] CALL_FRAME = 3'h2;
	localparam logic [2:0] IRQ_FRAME = 3'h5;

	// instructions driven by the sequencer
	typedef enum logic [3:0] {
		OP_NONE = 4'b0000,
		OP_ALU = 4'b0001,
		OP_LOAD_WORK = 4'b0010,
		OP_LOAD_IDX1 = 4'b0011,
		OP_LOAD_IDX2 = 4'b0100,
		OP_LOAD_STACK_LOW = 4'b0101,
		OP_LOAD_FLAGS = 4'b0110,
		OP_CARRY_SET = 4'b0111,
		OP_CARRY_CLEAR = 4'b1000,
		OP_MASK_SET = 4'b1001,
		OP_UNMASK = 4'b1010,
		OP_STACK_RESET = 4'b1011,
		OP_PUSH = 4'b1100,
		OP_POP = 4'b1101,
		OP_CALL = 4'b1110,
		OP_RET = 4'b1111
	} core_op_e;

	// alu result handed to the flag logic
	typedef struct packed {
		logic [7:0] value;
		logic upd_nibble;
		logic nibble;
		logic upd_carry;
		logic carry;
		logic upd_work;
	} alu_result_s;

	// reset vector fetch, interrupt entry / return sequence states
	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b000,
		SEQ_RESET_LO = 3'b001,
		SEQ_RESET_HI = 3'b010,
		SEQ_ENTRY = 3'b011,
		SEQ_VEC_LO = 3'b100,
		SEQ_VEC_HI = 3'b101,
		SEQ_RETURN = 3'b110
	} seq_state_e;

endpackage

/* hw/core_regs.sv */
// Contract
// - registers are not on any bus address
// - work register is 8-bit ALU accumulator
// - two 8-bit index registers
// - interrupts never save second index register
// - 16-bit fetch pointer split low/high
// - flags 8-bit, reset 111x1xxx, mask set
// - nibble carry from bit 3 on add
// - mask set by entry or mask op
// - masked requests stay pending until unmasked
// - handler return clears the mask
// - unmask in handler services pending immediately
// - sign flag copies result bit 7
// - zero flag set on zero result
// - carry from arithmetic, set/clear ops, shifts
// - stack pointer resets to 01FFh
// - post-decrement push, pre-increment pop
// - 256-byte stack, upper byte fixed
// - reset and stack reset op load FFh low
// - stack low byte wraps silently
// - stack low byte loadable and readable
// - entry pushes fetch pointer low first
// - call two bytes, interrupt five bytes
// - reset loads fetch pointer from FFFEh-FFFFh
// - entry saves pointer, index, work, flags
// - trap enters regardless of mask
module core_regs
	import core_regs_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	// sequencer instruction port
	input wire core_op_e op,
	input wire logic [7:0] op_data,
	input wire alu_result_s alu,
	input wire logic fetch_load,
	input wire logic [15:0] fetch_target,
	input wire logic fetch_advance,
	// interrupt side
	input wire logic irq_req,
	input wire logic [15:0] irq_vector,
	input wire logic trap_op,
	input wire logic handler_return_op,
	output logic irq_taken,
	// memory port for stack and vector traffic
	output logic mem_we,
	output logic mem_re,
	output logic [15:0] mem_addr,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	output logic seq_busy,
	// register values
	output logic [7:0] work_reg,
	output logic [7:0] index1_reg,
	output logic [7:0] index2_reg,
	output logic [15:0] next_fetch_pointer,
	output logic [7:0] condition_flags,
	output logic [15:0] stack_pointer
);

	// reset release through two flops
	logic rst_s1_q, rst_s2_q;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	logic rst_n;
	assign rst_n = rst_s2_q;

	logic [7:0] work_q, idx1_q, idx2_q, flags_q, stack_low_q;
	logic [7:0] fetch_pointer_low_q, fetch_pointer_high_q;
	seq_state_e state_q;
	logic [2:0] step_q;
	logic trap_q;
	logic [15:0] vec_q;

	// stack address: upper byte fixed by hardware
	function automatic logic [15:0] stack_addr(input logic [7:0] low);
		stack_addr = {STACK_PAGE, low};
	endfunction

	// byte saved at each step of the five-byte context frame
	function automatic logic [7:0] frame_byte(input logic [2:0] k, input logic [7:0] pl, input logic [7:0] ph,
			input logic [7:0] x, input logic [7:0] a, input logic [7:0] f);
		case (k)
			3'h0: frame_byte = pl;
			3'h1: frame_byte = ph;
			3'h2: frame_byte = x;
			3'h3: frame_byte = a;
			default: frame_byte = f;
		endcase
	endfunction

	// pending request, pending survives while masked
	logic take_irq, take_trap;
	assign take_trap = trap_op && state_q == SEQ_IDLE;
	assign take_irq = irq_req && !flags_q[FLAG_MASK] && state_q == SEQ_IDLE && !take_trap;
	logic take_ret;
	assign take_ret = handler_return_op && state_q == SEQ_IDLE && !take_trap && !take_irq;
	// plain op only when no sequence starts this cycle, else its side effects would corrupt the frame
	logic op_ok;
	assign op_ok = state_q == SEQ_IDLE && !take_trap && !take_irq && !take_ret;

	// sequencer for reset vector fetch, entry and return
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= SEQ_RESET_LO;
			step_q <= 3'h0;
			trap_q <= 1'b0;
			vec_q <= RESET_VECTOR_LO;
		end else begin
			case (state_q)
				SEQ_IDLE: begin
					step_q <= 3'h0;
					if (take_trap || take_irq) begin
						state_q <= SEQ_ENTRY;
						trap_q <= take_trap;
						vec_q <= take_trap ? TRAP_VECTOR_LO : irq_vector;
					end else if (take_ret) begin
						state_q <= SEQ_RETURN;
					end
				end
				SEQ_RESET_LO: state_q <= SEQ_RESET_HI;
				SEQ_RESET_HI: state_q <= SEQ_IDLE;
				SEQ_ENTRY: begin
					step_q <= step_q + 3'h1;
					if (step_q == IRQ_FRAME - 3'h1) begin
						state_q <= SEQ_VEC_LO;
					end
				end
				SEQ_VEC_LO: state_q <= SEQ_VEC_HI;
				SEQ_VEC_HI: state_q <= SEQ_IDLE;
				SEQ_RETURN: begin
					step_q <= step_q + 3'h1;
					if (step_q == IRQ_FRAME - 3'h1) begin
						state_q <= SEQ_IDLE;
					end
				end
				default: state_q <= SEQ_IDLE;
			endcase
		end
	end

	logic [2:0] ret_slot;
	assign ret_slot = IRQ_FRAME - 3'h1 - step_q; // flags popped first

	// memory port drive
	always_comb begin
		mem_we = 1'b0;
		mem_re = 1'b0;
		mem_addr = stack_addr(stack_low_q);
		mem_wdata = 8'h00;
		case (state_q)
			SEQ_RESET_LO: begin
				mem_re = 1'b1;
				mem_addr = RESET_VECTOR_HI;
			end
			SEQ_RESET_HI: begin
				mem_re = 1'b1;
				mem_addr = RESET_VECTOR_LO;
			end
			SEQ_ENTRY: begin
				mem_we = 1'b1;
				mem_wdata = frame_byte(step_q, fetch_pointer_low_q, fetch_pointer_high_q, idx1_q, work_q,
					flags_q);
			end
			SEQ_VEC_LO: begin
				mem_re = 1'b1;
				mem_addr = vec_q + 16'h0001;
			end
			SEQ_VEC_HI: begin
				mem_re = 1'b1;
				mem_addr = vec_q;
			end
			SEQ_RETURN: begin
				mem_re = 1'b1;
				mem_addr = stack_addr(stack_low_q + 8'h01);
			end
			default: begin
				if (op_ok && op == OP_PUSH) begin
					mem_we = 1'b1;
					mem_wdata = op_data;
				end else if (op_ok && op == OP_POP) begin
					mem_re = 1'b1;
					mem_addr = stack_addr(stack_low_q + 8'h01);
				end
			end
		endcase
	end

	assign seq_busy = state_q != SEQ_IDLE;
	assign irq_taken = take_irq || take_trap;

	// stack pointer low byte
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stack_low_q <= STACK_LOW_TOP;
		end else if (state_q == SEQ_ENTRY) begin
			stack_low_q <= stack_low_q - 8'h01;
		end else if (state_q == SEQ_RETURN) begin
			stack_low_q <= stack_low_q + 8'h01;
		end else if (op_ok) begin
			case (op)
				OP_STACK_RESET: stack_low_q <= STACK_LOW_TOP;
				OP_LOAD_STACK_LOW: stack_low_q <= op_data;
				OP_PUSH: stack_low_q <= stack_low_q - 8'h01;
				OP_POP: stack_low_q <= stack_low_q + 8'h01;
				OP_CALL: stack_low_q <= stack_low_q - {5'h00, CALL_FRAME};
				OP_RET: stack_low_q <= stack_low_q + {5'h00, CALL_FRAME};
				default: stack_low_q <= stack_low_q;
			endcase
		end
	end

	// work and first index register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			work_q <= 8'h00;
			idx1_q <= 8'h00;
		end else if (state_q == SEQ_RETURN) begin
			if (ret_slot == 3'h3) work_q <= mem_rdata;
			if (ret_slot == 3'h2) idx1_q <= mem_rdata;
		end else if (op_ok) begin
			if (op == OP_LOAD_WORK || (op == OP_ALU && alu.upd_work)) begin
				work_q <= op == OP_LOAD_WORK ? op_data : alu.value;
			end
			if (op == OP_LOAD_IDX1) idx1_q <= op_data;
		end
	end

	// second index register, untouched by entry/return
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			idx2_q <= 8'h00;
		end else if (op_ok && op == OP_LOAD_IDX2) begin
			idx2_q <= op_data;
		end
	end

	// fetch pointer halves
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fetch_pointer_low_q <= 8'h00;
			fetch_pointer_high_q <= 8'h00;
		end else begin
			case (state_q)
				SEQ_RESET_LO, SEQ_VEC_LO: fetch_pointer_low_q <= mem_rdata;
				SEQ_RESET_HI, SEQ_VEC_HI: fetch_pointer_high_q <= mem_rdata;
				SEQ_RETURN: begin
					if (ret_slot == 3'h1) fetch_pointer_high_q <= mem_rdata;
					if (ret_slot == 3'h0) fetch_pointer_low_q <= mem_rdata;
				end
				SEQ_IDLE: begin
					if (fetch_load) begin
						{fetch_pointer_high_q, fetch_pointer_low_q} <= fetch_target;
					end else if (fetch_advance) begin
						{fetch_pointer_high_q, fetch_pointer_low_q} <=
							{fetch_pointer_high_q, fetch_pointer_low_q} + 16'h0001;
					end
				end
				default: fetch_pointer_low_q <= fetch_pointer_low_q;
			endcase
		end
	end

	// condition flags
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			flags_q <= FLAGS_RESET;
		end else if (state_q == SEQ_VEC_LO) begin
			flags_q[FLAG_MASK] <= 1'b1;
		end else if (state_q == SEQ_RETURN) begin
			if (ret_slot == 3'h4) flags_q <= mem_rdata | FLAGS_FIXED_ONES;
			if (step_q == IRQ_FRAME - 3'h1) flags_q[FLAG_MASK] <= 1'b0;
		end else if (op_ok) begin
			case (op)
				OP_ALU: begin
					flags_q[FLAG_SIGN] <= alu.value[7];
					flags_q[FLAG_ZERO] <= alu.value == 8'h00;
					if (alu.upd_nibble) flags_q[FLAG_NIBBLE] <= alu.nibble;
					if (alu.upd_carry) flags_q[FLAG_CARRY] <= alu.carry;
				end
				OP_LOAD_FLAGS: flags_q <= op_data | FLAGS_FIXED_ONES;
				OP_CARRY_SET: flags_q[FLAG_CARRY] <= 1'b1;
				OP_CARRY_CLEAR: flags_q[FLAG_CARRY] <= 1'b0;
				OP_MASK_SET: flags_q[FLAG_MASK] <= 1'b1;
				OP_UNMASK: flags_q[FLAG_MASK] <= 1'b0;
				default: flags_q <= flags_q;
			endcase
		end
	end

	// register views; no bus decode reaches these
	assign work_reg = work_q;
	assign index1_reg = idx1_q;
	assign index2_reg = idx2_q;
	assign next_fetch_pointer = {fetch_pointer_high_q, fetch_pointer_low_q};
	assign condition_flags = flags_q;
	assign stack_pointer = stack_addr(stack_low_q);

endmodule

/* verif/core_regs_sva.sv */
module core_regs_sva
	import core_regs_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire core_op_e op,
	input wire alu_result_s alu,
	input wire logic irq_req,
	input wire logic trap_op,
	input wire logic handler_return_op,
	input wire logic irq_taken,
	input wire logic mem_we,
	input wire logic seq_busy,
	input wire logic [7:0] index2_reg,
	input wire logic [7:0] condition_flags,
	input wire logic [15:0] stack_pointer
);
	timeunit 1ns;
	timeprecision 1ns;
	// plain op accepted this cycle
	wire logic go;
	assign go = !seq_busy && !trap_op && !handler_return_op && !(irq_req && !condition_flags[3]);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_b);
	property p_page;
		stack_pointer[15:8] == 8'h01;
	endproperty
	a_page: assert property (p_page) else $error("stack page moved");
	property p_ones;
		condition_flags[7:5] == 3'b111;
	endproperty
	a_ones: assert property (p_ones) else $error("flag top bits");
	property p_push;
		go && op == OP_PUSH |=> stack_pointer[7:0] == $past(stack_pointer[7:0]) - 8'h01;
	endproperty
	a_push: assert property (p_push) else $error("push step");
	property p_pop;
		go && op == OP_POP |=> stack_pointer[7:0] == $past(stack_pointer[7:0]) + 8'h01;
	endproperty
	a_pop: assert property (p_pop) else $error("pop step");
	property p_sign;
		go && op == OP_ALU |=> condition_flags[2] == $past(alu.value[7])
			&& condition_flags[1] == ($past(alu.value) == 8'h00);
	endproperty
	a_sign: assert property (p_sign) else $error("sign or zero");
	property p_stk_reset;
		go && op == OP_STACK_RESET |=> stack_pointer == 16'h01FF;
	endproperty
	a_stk_reset: assert property (p_stk_reset) else $error("stack reset");
	property p_frame;
		irq_taken |=> mem_we [*5] ##1 !mem_we;
	endproperty
	a_frame: assert property (p_frame) else $error("frame length");
	property p_idx2;
		irq_taken |=> $stable(index2_reg) [*7];
	endproperty
	a_idx2: assert property (p_idx2) else $error("index2 touched");
	property p_hold;
		!seq_busy && !trap_op && condition_flags[3] |-> !irq_taken;
	endproperty
	a_hold: assert property (p_hold) else $error("masked entry");
endmodule
bind core_regs core_regs_sva chk (.mclk(mclk), .rst_b(rst_b), .op(op), .alu(alu), .irq_req(irq_req),
	.trap_op(trap_op), .handler_return_op(handler_return_op), .irq_taken(irq_taken), .mem_we(mem_we),
	.seq_busy(seq_busy), .index2_reg(index2_reg), .condition_flags(condition_flags),
	.stack_pointer(stack_pointer));

/* verif/mem_model.sv */
module mem_model (
	input wire logic mclk,
	input wire logic mem_we,
	input wire logic mem_re,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:65535];
	logic [7:0] last_q = 8'h00;
	// async read; released bus shows inverse of last byte
	assign mem_rdata = mem_re ? mem[mem_addr] : ~last_q;
	always @(posedge mclk) begin
		if (mem_we) mem[mem_addr] <= mem_wdata;
		if (mem_re) last_q <= mem[mem_addr];
	end
	// vectors: reset, external, trap
	initial begin
		mem[16'hFFFE] = 8'h12;
		mem[16'hFFFF] = 8'h34;
		mem[16'hFFF0] = 8'h56;
		mem[16'hFFF1] = 8'h78;
		mem[16'hFFFC] = 8'h9A;
		mem[16'hFFFD] = 8'hBC;
	end
endmodule

/* verif/test_cpu_core_register_set.sv */
module test_cpu_core_register_set;
	timeunit 1ns;
	timeprecision 1ns;
	import core_regs_pkg::*;
	logic mclk = 0;
	logic rst_b = 0;
	core_op_e op = OP_NONE;
	logic [7:0] op_data = 8'h00;
	alu_result_s alu = '0;
	logic irq_req = 0;
	logic trap_op = 0;
	logic ret = 0;
	logic fetch_load = 0;
	logic fetch_advance = 0;
	logic [15:0] fetch_target = 16'h0000;
	logic irq_taken, mem_we, mem_re, seq_busy;
	logic [15:0] mem_addr, nfp, stk;
	logic [7:0] mem_wdata, mem_rdata, work, ix1, ix2, flags;
	int errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	int taken_n = 0;
	always #50 mclk = ~mclk;
	core_regs uut (.mclk(mclk), .rst_b(rst_b), .op(op), .op_data(op_data), .alu(alu), .fetch_load(fetch_load),
		.fetch_target(fetch_target), .fetch_advance(fetch_advance), .irq_req(irq_req), .irq_vector(16'hFFF0),
		.trap_op(trap_op), .handler_return_op(ret), .irq_taken(irq_taken), .mem_we(mem_we),
		.mem_re(mem_re), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.seq_busy(seq_busy), .work_reg(work), .index1_reg(ix1), .index2_reg(ix2),
		.next_fetch_pointer(nfp), .condition_flags(flags), .stack_pointer(stk));
	mem_model mm (.mclk(mclk), .mem_we(mem_we), .mem_re(mem_re), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
	task check(string name, logic [15:0] seen, logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task idle;
		while (seq_busy !== 1'b0) begin
			@(posedge mclk);
			#1;
		end
	endtask
	task do_op(core_op_e o, logic [7:0] d);
		idle;
		op = o;
		op_data = d;
		@(posedge mclk);
		#1 op = OP_NONE;
		// let an edge pass so the next call never re-drives op in this time step
		@(posedge mclk);
		#1;
	endtask
	// hang guard and entry counter
	always @(posedge mclk) begin
		cycles++;
		if (irq_taken === 1'b1) taken_n++;
		if (cycles > 3000) begin
			errors++;
			test_done;
		end
	end
	initial begin
		repeat (6) @(posedge mclk);
		#1 rst_b = 1;
		check("flags_rst", {8'h00, flags & 8'hE8}, 16'h00E8);
		check("stk_rst", stk, STACK_RESET);
		idle;
		check("boot", nfp, 16'h1234);
		fetch_target = 16'h12FF;
		fetch_load = 1;
		@(posedge mclk);
		#1 fetch_load = 0;
		check("ptr_load", nfp, 16'h12FF);
		fetch_advance = 1;
		@(posedge mclk);
		#1 fetch_advance = 0;
		check("ptr_step", nfp, 16'h1300);
		alu = '{8'h80, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
		do_op(OP_ALU, 8'h00);
		check("work", {8'h00, work}, 16'h0080);
		check("alu_f", {8'h00, flags}, 16'h00FD);
		alu = '{8'h00, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
		do_op(OP_ALU, 8'h00);
		check("zero_f", {8'h00, flags}, 16'h00EA);
		do_op(OP_CARRY_SET, 8'h00);
		check("carry_set", {8'h00, flags}, 16'h00EB);
		do_op(OP_CARRY_CLEAR, 8'h00);
		check("carry_clr", {8'h00, flags}, 16'h00EA);
		do_op(OP_LOAD_FLAGS, 8'h00);
		check("load_flags", {8'h00, flags}, 16'h00E0);
		do_op(OP_MASK_SET, 8'h00);
		check("mask_on", {8'h00, flags}, 16'h00E8);
		$display("flag tests done");
		do_op(OP_LOAD_STACK_LOW, 8'h00);
		check("load_stk", stk, 16'h0100);
		do_op(OP_PUSH, 8'h5A);
		check("push", stk, 16'h01FF);
		check("pushed", {8'h00, mm.mem[16'h0100]}, 16'h005A);
		do_op(OP_POP, 8'h00);
		check("pop", stk, 16'h0100);
		do_op(OP_CALL, 8'h00);
		check("call", stk, 16'h01FE);
		do_op(OP_RET, 8'h00);
		check("ret", stk, 16'h0100);
		do_op(OP_STACK_RESET, 8'h00);
		check("stk_reset", stk, 16'h01FF);
		$display("stack tests done");
		do_op(OP_LOAD_IDX1, 8'hAA);
		check("idx1", {8'h00, ix1}, 16'h00AA);
		do_op(OP_LOAD_IDX2, 8'h55);
		check("idx2", {8'h00, ix2}, 16'h0055);
		do_op(OP_LOAD_WORK, 8'h3C);
		check("work_ld", {8'h00, work}, 16'h003C);
		irq_req = 1;
		repeat (4) @(posedge mclk);
		#1 check("pending", taken_n[15:0], 16'h0000);
		do_op(OP_UNMASK, 8'h00);
		while (taken_n == 0) begin
			@(posedge mclk);
			#1;
		end
		irq_req = 0;
		idle;
		check("irq_stk", stk, 16'h01FA);
		check("irq_ptr", nfp, 16'h5678);
		check("irq_m", {15'h0000, flags[3]}, 16'h0001);
		check("irq_y", {8'h00, ix2}, 16'h0055);
		check("ptr_low_st", {8'h00, mm.mem[16'h01FF]}, 16'h0000);
		check("ptr_high_st", {8'h00, mm.mem[16'h01FE]}, 16'h0013);
		check("x_st", {8'h00, mm.mem[16'h01FD]}, 16'h00AA);
		check("work_st", {8'h00, mm.mem[16'h01FC]}, 16'h003C);
		check("flags_st", {8'h00, mm.mem[16'h01FB]}, 16'h00E0);
		do_op(OP_LOAD_WORK, 8'h00);
		do_op(OP_LOAD_IDX1, 8'h00);
		do_op(OP_LOAD_IDX2, 8'h66);
		ret = 1;
		@(posedge mclk);
		#1 ret = 0;
		idle;
		check("ret_stk", stk, 16'h01FF);
		check("ret_m", {15'h0000, flags[3]}, 16'h0000);
		check("ret_flags", {8'h00, flags}, 16'h00E0);
		check("ret_ptr", nfp, 16'h1300);
		check("ret_work", {8'h00, work}, 16'h003C);
		check("ret_idx1", {8'h00, ix1}, 16'h00AA);
		check("ret_y", {8'h00, ix2}, 16'h0066);
		do_op(OP_MASK_SET, 8'h00);
		trap_op = 1;
		@(posedge mclk);
		#1 trap_op = 0;
		idle;
		check("trap_stk", stk, 16'h01FA);
		check("trap_ptr", nfp, 16'h9ABC);
		check("trap_m", {15'h0000, flags[3]}, 16'h0001);
		irq_req = 1;
		repeat (2) @(posedge mclk);
		#1 check("held", taken_n[15:0], 16'h0002);
		do_op(OP_UNMASK, 8'h00);
		while (taken_n < 3) begin
			@(posedge mclk);
			#1;
		end
		irq_req = 0;
		idle;
		check("nest_stk", stk, 16'h01F5);
		check("nest_ptr", nfp, 16'h5678);
		check("nest_save", {8'h00, mm.mem[16'h01FA]}, 16'h00BC);
		$display("interrupt tests done");
		test_done;
	end
endmodule
